// file: pkg/pdo_sdo_map.vh
`ifndef PDO_SDO_MAP_VH
`define PDO_SDO_MAP_VH

// ----------------------------------------------------------------------
// Object indices
// ----------------------------------------------------------------------
`define IDX_RX_PDO1_COMM   16'h1400
`define IDX_RX_PDO2_COMM   16'h1401
`define IDX_RX_PDO1_MAP    16'h1600
`define IDX_RX_PDO2_MAP    16'h1601
`define IDX_TX_PDO1_COMM   16'h1800
`define IDX_TX_PDO2_COMM   16'h1801
`define IDX_TX_PDO1_MAP    16'h1a00
`define IDX_TX_PDO2_MAP    16'h1a01
`define IDX_CYCLE_SETTING  16'h3400
`define IDX_CYCLE_ACTUAL   16'h3401
`define IDX_STATE_CONTROL  16'h3402
`define IDX_STARTUP_STATE  16'h3403
`define IDX_PDO_ENABLE     16'h6f60

// ----------------------------------------------------------------------
// SDO framing
// ----------------------------------------------------------------------
`define SDO_REQ_BASE       11'h600
`define SDO_RSP_BASE       11'h580
`define CMD_READ           8'h40
`define CMD_READ_RSP       8'h43
`define CMD_WRITE_1B       8'h2b
`define CMD_WRITE_ACK      8'h60
`define TT_ASYNC_MFR       8'hfe

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define RST_ENTRY_COUNT    8'h00
`define RST_CYCLE          32'h0000_0000
`define TICK_US            100
`define CLK_MHZ            50
`define TICK_CYCLES        (`TICK_US * `CLK_MHZ)

`endif

// file: verilog/canopen_pdo_sdo_control.v
`include "pdo_sdo_map.vh"

// Operation
// - Type 254: cycle 0 sends at sample rate, else timer in 0.1 ms steps.
// - Actual-period object gives microseconds under type 254, zero otherwise.
// - Writing state control: 0 pre-operational, 1 operational, 2 toggles.
// - Reading state control returns present state, 0 or 1.
// - Start-up setting chooses state entered after power-up.
// - Operational at power-up only if PDO enable holds 1; 0 inhibits PDOs.
// - Two receive parameter and mapping sets, u8 counts, u32 entries.
// - Two transmit parameter and mapping sets, u8 counts, RW entries.
// - Requests on 0x600 plus node, answers on 0x580 plus node.
// - Read answer: command 0x43, echoed index, value low byte first.
// - Write uses 0x2b with data in byte 4; acknowledged with 0x60.
module canopen_pdo_sdo_control #(
    parameter NODE_W   = 7,
    parameter ENTRIES  = 4,
    parameter US_TICKS = 50
) (
    input  wire              sys_clk,
    input  wire              rst_b,
    input  wire [NODE_W-1:0] node_addr,
    input  wire [7:0]        startup_stored,
    input  wire [7:0]        enable_stored,
    input  wire              sample_tick,
    input  wire [31:0]       sample_period_us,
    input  wire              rx_valid,
    input  wire [10:0]       rx_id,
    input  wire [63:0]       rx_data,
    output reg               tx_valid,
    output reg  [10:0]       tx_id,
    output reg  [63:0]       tx_data,
    output reg               pdo_send,
    output reg               operational
);

// ----------------------------------------------------------------------
// Object storage
// ----------------------------------------------------------------------
    // Index 0..3 rx comm/map, 4..7 tx comm/map in map order.
    reg  [7:0]  count   [0:7];
    reg  [31:0] entry   [0:8*ENTRIES-1];
    reg  [31:0] cycle_setting;
    reg  [7:0]  startup_sel;
    reg  [7:0]  pdo_enable;
    reg         boot_done;
    reg  [31:0] tick_cnt;
    reg  [31:0] tenth_cnt;
    integer     i;
    wire [NODE_W-1:0] node_sync;

// ----------------------------------------------------------------------
// Address pin synchroniser
// ----------------------------------------------------------------------
    // The address switch is not clocked, so it is filtered before use.
    // The chain has no reset so that it has settled by the time reset
    // is released and the first request arrives.
    level_sync #(
        .W (NODE_W)
    ) i_addr_sync (
        .sys_clk (sys_clk),
        .din     (node_addr),
        .dout    (node_sync)
    );

// ----------------------------------------------------------------------
// Request fields
// ----------------------------------------------------------------------
    wire [7:0]  cmd  = rx_data[7:0];
    wire [15:0] idx  = rx_data[23:8];
    wire [7:0]  sub  = rx_data[31:24];
    wire [7:0]  wb   = rx_data[39:32];
    wire [10:0] node = {{(11-NODE_W){1'b0}}, node_sync};
    wire        for_me = rx_valid && (rx_id == `SDO_REQ_BASE + node);

    // Transmit set 1 comm parameter sub 2 holds the transmission type.
    wire [7:0]  tx_type  = entry[4*ENTRIES + 1][7:0];
    wire        type_254 = (tx_type == `TT_ASYNC_MFR);

    reg  [2:0]  set_sel;
    reg         set_hit;
    always @* begin
        set_hit = 1'b1;
        case (idx)
            `IDX_RX_PDO1_COMM: set_sel = 3'h0;
            `IDX_RX_PDO2_COMM: set_sel = 3'h1;
            `IDX_RX_PDO1_MAP:  set_sel = 3'h2;
            `IDX_RX_PDO2_MAP:  set_sel = 3'h3;
            `IDX_TX_PDO1_COMM: set_sel = 3'h4;
            `IDX_TX_PDO2_COMM: set_sel = 3'h5;
            `IDX_TX_PDO1_MAP:  set_sel = 3'h6;
            `IDX_TX_PDO2_MAP:  set_sel = 3'h7;
            default: begin
                set_sel = 3'h0;
                set_hit = 1'b0;
            end
        endcase
    end

    wire        sub_ok = (sub >= 8'h01) && (sub <= ENTRIES);
    wire [31:0] e_addr = {29'h0, set_sel} * ENTRIES + {24'h0, sub} - 32'h1;

    // Actual period: sample period or timer setting times 100 us.
    wire [31:0] actual_us = !type_254 ? 32'h0 :
                            (cycle_setting == 32'h0) ? sample_period_us :
                            cycle_setting * `TICK_US;

// ----------------------------------------------------------------------
// Read value mux
// ----------------------------------------------------------------------
    reg [31:0] rd_val;
    always @* begin
        rd_val = 32'h0;
        if (set_hit) begin
            if (sub == 8'h00)
                rd_val = {24'h0, count[set_sel]};
            else if (sub_ok)
                rd_val = entry[e_addr];
        end else begin
            case (idx)
                `IDX_CYCLE_SETTING: rd_val = cycle_setting;
                `IDX_CYCLE_ACTUAL:  rd_val = actual_us;
                `IDX_STATE_CONTROL: rd_val = {31'h0, operational};
                `IDX_STARTUP_STATE: rd_val = {24'h0, startup_sel};
                `IDX_PDO_ENABLE:    rd_val = {24'h0, pdo_enable};
                default:            rd_val = 32'h0;
            endcase
        end
    end

// ----------------------------------------------------------------------
// Request decode
// ----------------------------------------------------------------------
    // Frames that arrive on the boot edge are dropped, because the
    // stored settings are only being latched on that edge.
    wire        take     = for_me && boot_done;
    wire        is_read  = (cmd == `CMD_READ);
    wire        is_write = (cmd == `CMD_WRITE_1B);
    wire        wr_req   = take && is_write;
    wire        wr_count = wr_req && set_hit && (sub == 8'h00);
    wire        wr_entry = wr_req && set_hit && sub_ok;
    wire        wr_plain = wr_req && !set_hit;
    wire        wr_state = wr_plain && (idx == `IDX_STATE_CONTROL);

// ----------------------------------------------------------------------
// Node state
// ----------------------------------------------------------------------
    localparam ST_PREOP = 1'b0;
    localparam ST_OP    = 1'b1;

    // Values above 2 leave the state alone rather than guessing.
    reg         next_operational;
    always @* begin
        next_operational = operational;
        if (wr_state) begin
            case (wb)
                8'h00:   next_operational = ST_PREOP;
                8'h01:   next_operational = ST_OP;
                8'h02:   next_operational = !operational;
                default: next_operational = operational;
            endcase
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            operational <= ST_PREOP;
            boot_done   <= 1'b0;
        end else if (!boot_done) begin
            boot_done   <= 1'b1;
            operational <= (startup_stored == 8'h01) &&
                           (enable_stored == 8'h01);
        end else begin
            operational <= next_operational;
        end
    end

// ----------------------------------------------------------------------
// Indexed objects
// ----------------------------------------------------------------------
    // Only single-byte writes exist on this path, so wide objects
    // take the byte zero-extended.
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            for (i = 0; i < 8; i = i + 1)
                count[i] <= `RST_ENTRY_COUNT;
            for (i = 0; i < 8*ENTRIES; i = i + 1)
                entry[i] <= 32'h0;
        end else begin
            if (wr_count) begin
                count[set_sel] <= wb;
            end
            if (wr_entry) begin
                entry[e_addr] <= {24'h0, wb};
            end
        end
    end

// ----------------------------------------------------------------------
// Plain objects
// ----------------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            cycle_setting <= `RST_CYCLE;
            startup_sel   <= 8'h00;
            pdo_enable    <= 8'h00;
        end else if (!boot_done) begin
            startup_sel   <= startup_stored;
            pdo_enable    <= enable_stored;
        end else if (wr_plain) begin
            case (idx)
                `IDX_CYCLE_SETTING: cycle_setting <= {24'h0, wb};
                `IDX_STARTUP_STATE: startup_sel   <= wb;
                `IDX_PDO_ENABLE:    pdo_enable    <= wb;
                default: ;
            endcase
        end
    end

// ----------------------------------------------------------------------
// Response
// ----------------------------------------------------------------------
    // The answer leaves one cycle after each request, back to back too.
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            tx_valid <= 1'b0;
            tx_id    <= 11'h000;
            tx_data  <= 64'h0;
        end else begin
            tx_valid <= take;
            if (take) begin
                tx_id <= `SDO_RSP_BASE + node;
                if (is_read) begin
                    tx_data <= {rd_val, sub, idx, `CMD_READ_RSP};
                end else begin
                    tx_data <= {32'h0, sub, idx, `CMD_WRITE_ACK};
                end
            end
        end
    end

// ----------------------------------------------------------------------
// Tick timer
// ----------------------------------------------------------------------
    // One tick is 0.1 ms of clock cycles; the clock rate is a parameter.
    localparam TICK_LEN = `TICK_US * US_TICKS;

    // The timer is free-running from the setting, not tied to samples.
    // A new setting may make the first period short; later ones are exact.
    wire tick_end  = (tick_cnt == TICK_LEN - 1);
    wire timer_hit = tick_end && (tenth_cnt + 32'h1 >= cycle_setting);
    wire due       = (cycle_setting == 32'h0) ?
                     sample_tick : timer_hit;
    wire may_send  = operational && type_254 &&
                     (pdo_enable == 8'h01);

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            tick_cnt <= 32'h0;
        end else if (tick_end) begin
            tick_cnt <= 32'h0;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            tenth_cnt <= 32'h0;
        end else if (timer_hit) begin
            tenth_cnt <= 32'h0;
        end else if (tick_end) begin
            tenth_cnt <= tenth_cnt + 32'h1;
        end
    end

// ----------------------------------------------------------------------
// PDO release
// ----------------------------------------------------------------------
    // The timer keeps running in pre-operational, so returning to
    // operational does not restart the phase of the period.
    // Nothing goes out after the first cycle of pre-operational or of inhibition.
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            pdo_send <= 1'b0;
        end else begin
            pdo_send <= due && may_send;
        end
    end

endmodule // canopen_pdo_sdo_control

// ----------------------------------------------------------------------
// Three-stage input filter
// ----------------------------------------------------------------------
// A new level is passed on only once the second and third stages agree,
// so a bounce caught by the first stage for a single cycle never reaches the logic.
module level_sync #(
    parameter W = 1
) (
    input  wire         sys_clk,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);

    reg [W-1:0] stage1;
    reg [W-1:0] stage2;
    reg [W-1:0] stage3;

    always @(posedge sys_clk) begin
        stage1 <= din;
        stage2 <= stage1;
        stage3 <= stage2;
        if (stage2 == stage3)
            dout <= stage3;
    end

endmodule // level_sync

// file: verification/pdo_sdo_checker.sv
module pdo_sdo_checker #(parameter NODE_W = 7) (
    input wire              sys_clk,
    input wire              rst_b,
    input wire [NODE_W-1:0] node_addr,
    input wire [7:0]        startup_stored,
    input wire [7:0]        enable_stored,
    input wire              rx_valid,
    input wire [10:0]       rx_id,
    input wire [63:0]       rx_data,
    input wire              tx_valid,
    input wire [10:0]       tx_id,
    input wire [63:0]       tx_data,
    input wire              pdo_send,
    input wire              operational
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    // Frames on the boot edge are not taken, so up delays by one.
    reg  up;
    wire take = rx_valid && up && rx_id == 11'h600 + 11'(node_addr);
    wire st = take && rx_data[31:8] == 24'h003402;
    always @(posedge sys_clk) up <= rst_b;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sdo_answer_a: assert property (take |=> tx_valid &&
        tx_id == 11'h580 + 11'(node_addr)) else $error("bad answer id");
    foreign_id_a: assert property (!take |=> !tx_valid)
        else $error("unexpected answer");
    read_format_a: assert property (take && rx_data[7:0] == 8'h40
        |=> tx_data[31:0] == {$past(rx_data[31:8]), 8'h43})
        else $error("bad read");
    write_ack_a: assert property (take && rx_data[7:0] == 8'h2b |=>
        tx_data[31:0] == {$past(rx_data[31:8]), 8'h60})
        else $error("bad ack");
    boot_state_a: assert property (!up |=> operational ==
        ($past(startup_stored) == 8'h01 && $past(enable_stored) == 8'h01))
        else $error("bad start-up state");
    state_write_a: assert property (st && rx_data[7:0] == 8'h2b &&
        rx_data[39:32] <= 8'h02 |=> operational == ($past(rx_data[33]) ?
        !$past(operational) : $past(rx_data[32]))) else $error("bad state");
    state_read_a: assert property (st && rx_data[7:0] == 8'h40 |=>
        tx_data[63:32] == {31'h0, $past(operational)})
        else $error("bad state");
    preop_quiet_a: assert property (!operational &&
        !$past(operational) |-> !pdo_send) else $error("PDO while idle");
endmodule // pdo_sdo_checker

bind canopen_pdo_sdo_control pdo_sdo_checker #(.NODE_W(NODE_W)) i_chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .node_addr(node_addr),
    .startup_stored(startup_stored), .enable_stored(enable_stored),
    .rx_valid(rx_valid), .rx_id(rx_id), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_id(tx_id), .tx_data(tx_data),
    .pdo_send(pdo_send), .operational(operational));

// file: verification/can_master_model.sv
module can_master_model (
    input  wire         sys_clk,
    input  wire         tx_valid,
    input  wire  [63:0] tx_data,
    output logic        rx_valid = 1'b0,
    output logic [10:0] rx_id = 11'h000,
    output logic [63:0] rx_data = 64'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Expedited request and answer capture
    // ------------------------------------------------------------
    // Released lines show the inverse, never a stale valid frame.
    task automatic sdo(logic [10:0] id, logic [7:0] cmd, logic [15:0] idx,
            logic [7:0] sub, val, output logic [63:0] rsp, output logic ok);
        @(posedge sys_clk);
        rx_valid <= 1'b1;
        rx_id <= id;
        rx_data <= {24'ha5a5a5, val, sub, idx, cmd};
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rx_id <= ~id;
        rx_data <= ~rx_data;
        #1 ok = tx_valid;
        rsp = tx_data;
    endtask
endmodule // can_master_model

// file: verification/canopen_pdo_sdo_control_tb.sv
module canopen_pdo_sdo_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Bench
    // ------------------------------------------------------------
    logic        sys_clk = 0, rst_b = 0, sample_tick = 0, got;
    logic        rx_valid, tx_valid, pdo_send, operational;
    logic [7:0]  startup_stored = 8'h01, enable_stored = 8'h01;
    logic [10:0] rx_id, tx_id;
    logic [63:0] rx_data, tx_data, rsp;
    logic [15:0] objs [8] = '{16'h1400, 16'h1401, 16'h1600, 16'h1601,
                              16'h1800, 16'h1801, 16'h1a00, 16'h1a01};
    logic [7:0]  sv [4] = '{8'h00, 8'h01, 8'h02, 8'h02};
    int          num_errors = 0, checks_done = 0, npdo = 0;
    time         last = 0, gap = 0;
    canopen_pdo_sdo_control i_dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .node_addr(7'h03), .startup_stored(startup_stored),
        .enable_stored(enable_stored), .sample_tick(sample_tick),
        .sample_period_us(32'd1250), .rx_valid(rx_valid), .rx_id(rx_id),
        .rx_data(rx_data), .tx_valid(tx_valid), .tx_id(tx_id),
        .tx_data(tx_data), .pdo_send(pdo_send), .operational(operational));
    can_master_model i_master (.sys_clk(sys_clk), .tx_valid(tx_valid),
        .tx_data(tx_data), .rx_valid(rx_valid), .rx_id(rx_id),
        .rx_data(rx_data));
    initial forever #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (pdo_send === 1'b1) begin
        npdo++;
        gap = $time - last;
        last = $time;
    end
    task automatic check(logic [63:0] a, b);
        checks_done++;
        if (a !== b) begin
            num_errors++;
            $display("ERROR %0t: got %h want %h", $time, a, b);
        end
    endtask
    task automatic wr(logic [15:0] idx, logic [7:0] sub, val);
        i_master.sdo(11'h603, 8'h2b, idx, sub, val, rsp, got);
        check({got, tx_id, rsp[31:0]},
              {1'b1, 11'h583, sub, idx, 8'h60});
    endtask
    task automatic rd(logic [15:0] idx, logic [7:0] sub, logic [31:0] v);
        i_master.sdo(11'h603, 8'h40, idx, sub, 8'h5a, rsp, got);
        check({got, tx_id}, {1'b1, 11'h583});
        check(rsp, {v, sub, idx, 8'h43});
    endtask
    task automatic boot(logic [7:0] s, e, logic exp);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        startup_stored <= s;
        enable_stored <= e;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 check(operational, exp);
    endtask
    task automatic tick();
        @(posedge sys_clk) sample_tick <= 1'b1;
        @(posedge sys_clk) sample_tick <= 1'b0;
        #1;
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        boot(8'h01, 8'h01, 1'b1);
        rd(16'h3403, 8'h00, 32'h1);
        rd(16'h6f60, 8'h00, 32'h1);
        boot(8'h01, 8'h00, 1'b0);
        boot(8'h00, 8'h01, 1'b0);
        rd(16'h3402, 8'h00, 32'h0);
        $display("start-up test done");
        foreach (objs[i]) begin
            wr(objs[i], 8'h00, 8'h10 + 8'(i));
            wr(objs[i], 8'h01, 8'h80 + 8'(i));
            rd(objs[i], 8'h00, 32'h10 + 32'(i));
            rd(objs[i], 8'h01, 32'h80 + 32'(i));
        end
        rd(16'h2000, 8'h00, 32'h0);
        i_master.sdo(11'h604, 8'h40, 16'h3402, 8'h00, 8'h5a, rsp, got);
        check(got, 1'b0);
        $display("object test done");
        foreach (sv[i]) begin
            wr(16'h3402, 8'h00, sv[i]);
            check(operational, 64'(i % 2));
            rd(16'h3402, 8'h00, 32'(i % 2));
        end
        $display("state test done");
        wr(16'h1800, 8'h02, 8'hfe);
        rd(16'h3401, 8'h00, 32'd1250);
        tick();
        check(pdo_send, 1'b1);
        wr(16'h6f60, 8'h00, 8'h00);
        tick();
        check(pdo_send, 1'b0);
        wr(16'h6f60, 8'h00, 8'h01);
        wr(16'h3402, 8'h00, 8'h00);
        npdo = 0;
        tick();
        rd(16'h3402, 8'h00, 32'h0);
        check(npdo, 0);
        wr(16'h3402, 8'h00, 8'h01);
        wr(16'h3400, 8'h00, 8'h01);
        rd(16'h3400, 8'h00, 32'h1);
        rd(16'h3401, 8'h00, 32'd100);
        repeat (12000) @(posedge sys_clk);
        check(gap, 64'd100000);
        wr(16'h1800, 8'h02, 8'h01);
        rd(16'h3401, 8'h00, 32'h0);
        npdo = 0;
        repeat (6000) @(posedge sys_clk);
        check(npdo, 0);
        $display("cycle test done");
        report_and_stop();
    end
    initial begin
        #1_000_000 num_errors++;
        $display("ERROR %0t: timeout", $time);
        report_and_stop();
    end
endmodule // canopen_pdo_sdo_control_tb
